// ---- rtl/amr_defs.svh ----
// register indices, field positions, reset values and timing counts
// assumes: byte address of a register is four times its index
`ifndef AMR_DEFS_SVH
`define AMR_DEFS_SVH

`define AMR_IDX_CONTROL       6'h00
`define AMR_IDX_CLKDIV        6'h01
`define AMR_IDX_SAMPLEN       6'h08
`define AMR_IDX_COMMAND       6'h0a
`define AMR_IDX_AMPCTRL       6'h0b
`define AMR_IDX_POSSEL        6'h0c
`define AMR_IDX_NEGSEL        6'h0d
`define AMR_IDX_RESULT0       6'h10
`define AMR_IDX_RESULT3       6'h13
`define AMR_IDX_SAMPLE0       6'h14
`define AMR_IDX_SAMPLE1       6'h15

`define AMR_AMPCTRL_RESET     8'h04
`define AMR_MUX_RESET         8'h00
`define AMR_CLKDIV_RESET      8'h03

`define AMR_LOW_LATENCY_KEEP_ON_BIT        0
`define AMR_BIAS_MSB          4
`define AMR_BIAS_LSB          3
`define AMR_AMPLEN_MSB        2
`define AMR_AMPLEN_LSB        1
`define AMR_AMPEN_BIT         0
`define AMR_VIA_MSB           7
`define AMR_VIA_LSB           6
`define AMR_SEL_MSB           5

`define AMR_VIA_DIRECT        2'h0
`define AMR_VIA_AMP           2'h1
`define AMR_START_ON_POS      3'h2
`define AMR_START_ON_NEG      3'h3

`define AMR_SEL_DEFAULT       6'h00
`define AMR_SEL_GND           6'h30
`define AMR_SEL_SUPPLY        6'h31
`define AMR_SEL_TEMP          6'h32
`define AMR_SEL_REF           6'h33
`define AMR_POS_PIN_LAST      6'h0f
`define AMR_NEG_PIN_LAST      6'h07

`define AMR_AMP_SAMPLE_6      9'd6
`define AMR_AMP_SAMPLE_15     9'd15
`define AMR_AMP_SAMPLE_20     9'd20

`endif

// ---- rtl/amr_pkg.sv ----
// types shared by the converter front-end register block
// assumes: nothing beyond the defines header
package amr_pkg;

    typedef enum logic [2:0] {
        AMR_IN_GROUND,
        AMR_IN_PIN,
        AMR_IN_SUPPLY_DIV_TEN,
        AMR_IN_TEMPERATURE,
        AMR_IN_COMPARATOR_REF,
        AMR_IN_RESERVED
    } amr_input_kind_t;

    typedef enum logic [1:0] {
        AMR_PH_IDLE,
        AMR_PH_INPUT,
        AMR_PH_AMP
    } amr_phase_t;

endpackage

// ---- rtl/amr_regs.sv ----
// register block for the converter input multiplexers, amplifier and results
// assumes: APB master on ref_clk; converter core supplies results with a done pulse
//
// Operation
// - bias field bits 4:3 drives bias code
// - sample field picks 6, 15, 20 ticks
// - amplifier powered only when enabled and either routed or low latency set
// - enable plus low latency keeps amplifier on
// - routing field: 0 direct, 1 via amplifier
// - one routing copy shared by both selectors
// - positive selector codes decoded to inputs
// - negative selector codes, no temperature sensor
// - both selector registers reset to zero
// - result: four read-only bytes from 0x10
// - latest sample: two read-only bytes 0x14
// - selector write starts conversion per start code
// - amplifier routing: input phase length plus amplifier phase length (6, 15 or 20 ticks)
//
// Local design decision: the APB slave port.
`include "amr_defs.svh"
module amr_regs
    import amr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        convDone,
    input  wire logic [31:0] convResult,
    input  wire logic [15:0] convSample,
    output logic [1:0]       ampBias,
    output logic             ampPowerOn,
    output logic             routeViaAmp,
    output amr_input_kind_t  posKind,
    output logic [3:0]       posPin,
    output amr_input_kind_t  negKind,
    output logic [3:0]       negPin,
    output logic             adcTick,
    output logic             convStart,
    output logic             inputSampling,
    output logic             ampSampling,
    output logic             sampleDone
);
    logic [7:0]      controlReg;
    logic [7:0]      clkDivReg;
    logic [7:0]      sampLenReg;
    logic [7:0]      commandReg;
    logic [7:0]      ampCtrlReg;
    logic [5:0]      posSelReg;
    logic [5:0]      negSelReg;
    logic [1:0]      viaReg;
    logic [31:0]     resultReg;
    logic [15:0]     sampleReg;
    logic [31:0]     prdataReg;
    logic            errReg;
    logic [7:0]      divCountReg;
    logic            tickReg;
    logic            startReg;
    amr_input_kind_t posKindReg;
    amr_input_kind_t negKindReg;
    logic [3:0]      posPinReg;
    logic [3:0]      negPinReg;
    logic [5:0]      regIdx;
    logic            setupPhase;
    logic            wrAccess;
    logic [31:0]     rdNext;
    logic            hitNext;

    // byte offsets map to word index; low address bits must be zero
    function automatic logic [5:0] wordIndex(input logic [7:0] addr);
        wordIndex = addr[7:2];
    endfunction

    function automatic amr_input_kind_t decodeInput(input logic [5:0] code,
                                                    input logic       isPos);
        logic [5:0] pinLast;
        pinLast = isPos ? `AMR_POS_PIN_LAST : `AMR_NEG_PIN_LAST;
        if (code == `AMR_SEL_DEFAULT || code == `AMR_SEL_GND) begin
            decodeInput = AMR_IN_GROUND;
        end else if (code == `AMR_SEL_SUPPLY) begin
            decodeInput = AMR_IN_SUPPLY_DIV_TEN;
        end else if (code == `AMR_SEL_TEMP) begin
            decodeInput = isPos ? AMR_IN_TEMPERATURE : AMR_IN_RESERVED;
        end else if (code == `AMR_SEL_REF) begin
            decodeInput = AMR_IN_COMPARATOR_REF;
        end else if (code <= pinLast) begin
            decodeInput = AMR_IN_PIN;
        end else begin
            decodeInput = AMR_IN_RESERVED;
        end
    endfunction

    assign regIdx     = wordIndex(paddr);
    assign setupPhase = psel && !penable;
    assign wrAccess   = psel && penable && pwrite && (paddr[1:0] == 2'b00);

    // read mux; unmapped or misaligned addresses flag an error
    always_comb begin
        rdNext  = 32'h0000_0000;
        hitNext = (paddr[1:0] == 2'b00);
        unique case (regIdx)
            `AMR_IDX_CONTROL: rdNext[7:0] = controlReg;
            `AMR_IDX_CLKDIV:  rdNext[7:0] = clkDivReg;
            `AMR_IDX_SAMPLEN: rdNext[7:0] = sampLenReg;
            `AMR_IDX_COMMAND: rdNext[7:0] = commandReg;
            `AMR_IDX_AMPCTRL: rdNext[7:0] = ampCtrlReg;
            `AMR_IDX_POSSEL:  rdNext[7:0] = {viaReg, posSelReg};
            `AMR_IDX_NEGSEL:  rdNext[7:0] = {viaReg, negSelReg};
            6'h10:            rdNext[7:0] = resultReg[7:0];
            6'h11:            rdNext[7:0] = resultReg[15:8];
            6'h12:            rdNext[7:0] = resultReg[23:16];
            `AMR_IDX_RESULT3: rdNext[7:0] = resultReg[31:24];
            `AMR_IDX_SAMPLE0: rdNext[7:0] = sampleReg[7:0];
            `AMR_IDX_SAMPLE1: rdNext[7:0] = sampleReg[15:8];
            default:          hitNext = 1'b0;
        endcase
    end

    // answer is prepared in the setup cycle so the access phase never waits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdataReg <= 32'h0000_0000;
            errReg    <= 1'b0;
        end else if (setupPhase) begin
            prdataReg <= pwrite ? 32'h0000_0000 : rdNext;
            errReg    <= !hitNext;
        end
    end

    assign prdata  = prdataReg;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && errReg;

    // software-written control state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            controlReg <= 8'h00;
            clkDivReg  <= `AMR_CLKDIV_RESET;
            sampLenReg <= 8'h00;
            commandReg <= 8'h00;
            ampCtrlReg <= `AMR_AMPCTRL_RESET;
        end else if (wrAccess) begin
            unique case (regIdx)
                `AMR_IDX_CONTROL: controlReg <= pwdata[7:0];
                `AMR_IDX_CLKDIV:  clkDivReg  <= pwdata[7:0];
                `AMR_IDX_SAMPLEN: sampLenReg <= pwdata[7:0];
                `AMR_IDX_COMMAND: commandReg <= pwdata[7:0];
                `AMR_IDX_AMPCTRL: ampCtrlReg <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // selector registers with one shared routing field
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            posSelReg <= 6'(`AMR_MUX_RESET);
            negSelReg <= 6'(`AMR_MUX_RESET);
            viaReg    <= `AMR_VIA_DIRECT;
        end else if (wrAccess) begin
            if (regIdx == `AMR_IDX_POSSEL) begin
                posSelReg <= pwdata[`AMR_SEL_MSB:0];
                viaReg    <= pwdata[`AMR_VIA_MSB:`AMR_VIA_LSB];
            end else if (regIdx == `AMR_IDX_NEGSEL) begin
                negSelReg <= pwdata[`AMR_SEL_MSB:0];
                viaReg    <= pwdata[`AMR_VIA_MSB:`AMR_VIA_LSB];
            end
        end
    end

    // selector decode registered so the analog switches see clean codes
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            posKindReg <= AMR_IN_GROUND;
            negKindReg <= AMR_IN_GROUND;
            posPinReg  <= 4'h0;
            negPinReg  <= 4'h0;
        end else begin
            posKindReg <= decodeInput(posSelReg, 1'b1);
            negKindReg <= decodeInput(negSelReg, 1'b0);
            // pin number registered with its kind, so both switch in the same cycle
            posPinReg  <= (decodeInput(posSelReg, 1'b1) == AMR_IN_PIN)
                          ? posSelReg[3:0] : 4'h0;
            negPinReg  <= (decodeInput(negSelReg, 1'b0) == AMR_IN_PIN)
                          ? negSelReg[3:0] : 4'h0;
        end
    end

    assign posKind = posKindReg;
    assign negKind = negKindReg;
    assign posPin  = posPinReg;
    assign negPin  = negPinReg;

    assign ampBias     = ampCtrlReg[`AMR_BIAS_MSB:`AMR_BIAS_LSB];
    assign routeViaAmp = (viaReg == `AMR_VIA_AMP);
    // low latency trades idle power for no amplifier start-up delay
    assign ampPowerOn  = ampCtrlReg[`AMR_AMPEN_BIT]
                         && (routeViaAmp || controlReg[`AMR_LOW_LATENCY_KEEP_ON_BIT]);

    // selector write with matching start code kicks a conversion
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            startReg <= 1'b0;
        end else begin
            startReg <= wrAccess
                && ((regIdx == `AMR_IDX_POSSEL && commandReg[2:0] == `AMR_START_ON_POS)
                 || (regIdx == `AMR_IDX_NEGSEL && commandReg[2:0] == `AMR_START_ON_NEG));
        end
    end

    assign convStart = startReg;

    // converter clock enable: one tick every clkDiv+1 system cycles
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            divCountReg <= 8'h00;
            tickReg     <= 1'b0;
        end else if (divCountReg >= clkDivReg) begin
            divCountReg <= 8'h00;
            tickReg     <= 1'b1;
        end else begin
            divCountReg <= divCountReg + 8'h01;
            tickReg     <= 1'b0;
        end
    end

    assign adcTick = tickReg;

    // results are read-only; only the converter core updates them
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            resultReg <= 32'h0000_0000;
            sampleReg <= 16'h0000;
        end else if (convDone) begin
            resultReg <= convResult;
            sampleReg <= convSample;
        end
    end

    amr_sample_timer u_timer (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .tick          (tickReg),
        .start         (startReg),
        .viaAmp        (routeViaAmp),
        .sampLen       (sampLenReg),
        .ampLenCode    (ampCtrlReg[`AMR_AMPLEN_MSB:`AMR_AMPLEN_LSB]),
        .inputSampling (inputSampling),
        .ampSampling   (ampSampling),
        .sampleDone    (sampleDone)
    );

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    chk_bias_from_write: assert property (
        (wrAccess && regIdx == `AMR_IDX_AMPCTRL) |=> ampBias == $past(pwdata[4:3]))
        else $error("bias code does not follow written field");

    chk_amp_off_gate: assert property (
        (wrAccess && regIdx == `AMR_IDX_AMPCTRL && !pwdata[0]) |=> !ampPowerOn)
        else $error("amplifier powered while its enable is clear");

    chk_amp_needs_route: assert property (
        (ampPowerOn && !controlReg[0]) |-> viaReg == 2'h1)
        else $error("amplifier powered without amplifier routing");

    chk_amp_keep_on: assert property (
        (ampCtrlReg[0] && controlReg[0]) |-> ampPowerOn)
        else $error("low latency did not keep amplifier on");

    chk_route_shared: assert property (
        (wrAccess && regIdx == `AMR_IDX_NEGSEL) |=>
            routeViaAmp == ($past(pwdata[7:6]) == 2'h1) && $stable(posSelReg))
        else $error("routing write through negative selector mishandled");

    chk_pos_pin_range: assert property (
        posKind == AMR_IN_PIN |-> (posPin != 4'h0 && $past(posSelReg) <= 6'h0f))
        else $error("positive pin decode out of range");

    chk_neg_no_temp: assert property (
        (negKind != AMR_IN_TEMPERATURE) and (negKind == AMR_IN_PIN |-> negPin <= 4'h7))
        else $error("negative selector decoded an illegal input");

    chk_result_read: assert property (
        (setupPhase && !pwrite && paddr == 8'h44 && !convDone) |=>
            prdata == {24'h000000, resultReg[15:8]})
        else $error("result byte one read back wrong");

    chk_sample_read: assert property (
        (setupPhase && !pwrite && paddr == 8'h54 && !convDone) |=>
            prdata == {24'h000000, sampleReg[15:8]})
        else $error("sample high byte read back wrong");

    chk_start_on_pos: assert property (
        (wrAccess && regIdx == `AMR_IDX_POSSEL && commandReg[2:0] == 3'h2) |=>
            convStart ##1 !convStart)
        else $error("positive selector write did not start conversion");

    chk_start_cause: assert property (
        convStart |-> $past(wrAccess) && ($past(regIdx) == 6'h0c || $past(regIdx) == 6'h0d))
        else $error("conversion started without a selector write");
endmodule

// ---- rtl/amr_sample_timer.sv ----
// sample phase sequencer counted in converter-clock ticks
// assumes: tick is a one-cycle enable from the divider in the register block
`include "amr_defs.svh"
module amr_sample_timer
    import amr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       tick,
    input  wire logic       start,
    input  wire logic       viaAmp,
    input  wire logic [7:0] sampLen,
    input  wire logic [1:0] ampLenCode,
    output logic            inputSampling,
    output logic            ampSampling,
    output logic            sampleDone
);
    amr_phase_t phase_reg;
    logic [8:0] count_reg;
    logic       done_reg;
    logic [8:0] inputLen;
    logic [8:0] ampLen;

    // reserved code 3 behaves as the longest setting
    function automatic logic [8:0] ampLenOf(input logic [1:0] code);
        unique case (code)
            2'h0:    ampLenOf = `AMR_AMP_SAMPLE_6;
            2'h1:    ampLenOf = `AMR_AMP_SAMPLE_15;
            default: ampLenOf = `AMR_AMP_SAMPLE_20;
        endcase
    endfunction

    assign inputLen = {1'b0, sampLen} + 9'd1;
    assign ampLen   = ampLenOf(ampLenCode);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg <= AMR_PH_IDLE;
            count_reg <= 9'h000;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start) begin
                phase_reg <= AMR_PH_INPUT;
                count_reg <= 9'h000;
            end else if (tick) begin
                unique case (phase_reg)
                    AMR_PH_IDLE: begin
                    end
                    AMR_PH_INPUT: begin
                        if (count_reg == inputLen - 9'd1) begin
                            count_reg <= 9'h000;
                            phase_reg <= viaAmp ? AMR_PH_AMP : AMR_PH_IDLE;
                            done_reg  <= !viaAmp;
                        end else begin
                            count_reg <= count_reg + 9'd1;
                        end
                    end
                    AMR_PH_AMP: begin
                        if (count_reg == ampLen - 9'd1) begin
                            count_reg <= 9'h000;
                            phase_reg <= AMR_PH_IDLE;
                            done_reg  <= 1'b1;
                        end else begin
                            count_reg <= count_reg + 9'd1;
                        end
                    end
                endcase
            end
        end
    end

    assign inputSampling = (phase_reg == AMR_PH_INPUT);
    assign ampSampling   = (phase_reg == AMR_PH_AMP);
    assign sampleDone    = done_reg;

    chk_amp_phase_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (ampSampling && tick && !start && count_reg == ampLen - 9'd1) |=> sampleDone)
        else $error("amplifier sample phase did not end on its count");

    chk_input_phase_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (inputSampling && count_reg > {1'b0, sampLen}) |-> 1'b0)
        else $error("input sample phase ran past its length");
endmodule

// ---- sim/amr_tb.sv ----
// self-checking bench for the converter front-end register block
// assumes: amr_regs reached over APB only; converter core side driven here
`include "amr_defs.svh"
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb
    import amr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic       neg;
        logic [7:0] wr;
        logic [2:0] kind;
        logic [3:0] pin;
    } amr_tb_row_t;
    logic            ref_clk = 1'b0;
    logic            rst_b = 1'b0;
    logic            psel = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite = 1'b0;
    logic [7:0]      paddr = 8'h00;
    logic [31:0]     pwdata = 32'h0;
    logic [31:0]     prdata;
    logic            pready, pslverr;
    logic            convDone = 1'b0;
    logic [31:0]     convResult = 32'h0;
    logic [15:0]     convSample = 16'h0;
    logic [1:0]      ampBias;
    logic            ampPowerOn, routeViaAmp, adcTick, convStart;
    amr_input_kind_t posKind, negKind;
    logic [3:0]      posPin, negPin;
    logic            inputSampling, ampSampling, sampleDone;
    int              fails = 0;
    int              testsRun = 0;
    int              nTick;
    logic [31:0]     rdv;
    logic            errv;
    amr_tb_row_t     rows [16];
    int              ampLen [3] = '{6, 15, 20};

    amr_regs amr_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .convDone(convDone), .convResult(convResult),
        .convSample(convSample), .ampBias(ampBias), .ampPowerOn(ampPowerOn),
        .routeViaAmp(routeViaAmp), .posKind(posKind), .posPin(posPin), .negKind(negKind),
        .negPin(negPin), .adcTick(adcTick), .convStart(convStart),
        .inputSampling(inputSampling), .ampSampling(ampSampling), .sampleDone(sampleDone));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    function automatic logic [7:0] regAddr(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", testsRun, fails);
        if (fails == 0 && testsRun > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // answer taken at the very edge that samples pready high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int   n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (pready === 1'b1) begin
                rd = prdata;
                err = pslverr;
                break;
            end
            n++;
            if (n > 50) begin
                fails++;
                stop_test();
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr8(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, regAddr(idx), {24'h0, d}, rdv, errv);
    endtask

    task automatic rdChk(input logic [5:0] idx, input logic [31:0] exp);
        apb(1'b0, regAddr(idx), 32'h0, rdv, errv);
        `CHK(rdv, exp)
        `CHK(errv, 1'b0)
    endtask

    task automatic settle();
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    // convStart must show in the cycle right after the write edge
    task automatic runConv(input logic [5:0] idx, input logic [7:0] d, input int expIn,
                           input int expAmp);
        int nIn, nAmp, nDone;
        nIn = 0;
        nAmp = 0;
        nDone = 0;
        wr8(idx, d);
        @(negedge ref_clk);
        `CHK(convStart, 1'b1)
        for (int i = 0; i < 60; i++) begin
            @(negedge ref_clk);
            nIn += int'(inputSampling === 1'b1);
            nAmp += int'(ampSampling === 1'b1);
            nDone += int'(sampleDone === 1'b1);
        end
        `CHK(nIn, expIn)
        `CHK(nAmp, expAmp)
        `CHK(nDone, 1)
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        stop_test();
    end

    initial begin
        rows = '{
            '{1'b0, 8'h00, AMR_IN_GROUND, 4'h0}, '{1'b0, 8'h30, AMR_IN_GROUND, 4'h0},
            '{1'b0, 8'h01, AMR_IN_PIN, 4'h1}, '{1'b0, 8'h0f, AMR_IN_PIN, 4'hf},
            '{1'b0, 8'h10, AMR_IN_RESERVED, 4'h0}, '{1'b0, 8'h31, AMR_IN_SUPPLY_DIV_TEN, 4'h0},
            '{1'b0, 8'h32, AMR_IN_TEMPERATURE, 4'h0}, '{1'b0, 8'h33, AMR_IN_COMPARATOR_REF, 4'h0},
            '{1'b0, 8'h34, AMR_IN_RESERVED, 4'h0}, '{1'b1, 8'h00, AMR_IN_GROUND, 4'h0},
            '{1'b1, 8'h07, AMR_IN_PIN, 4'h7}, '{1'b1, 8'h08, AMR_IN_RESERVED, 4'h0},
            '{1'b1, 8'h31, AMR_IN_SUPPLY_DIV_TEN, 4'h0}, '{1'b1, 8'h32, AMR_IN_RESERVED, 4'h0},
            '{1'b1, 8'h33, AMR_IN_COMPARATOR_REF, 4'h0}, '{1'b1, 8'h30, AMR_IN_GROUND, 4'h0}};
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        `CHK(posKind, AMR_IN_GROUND)
        `CHK(routeViaAmp, 1'b0)
        rdChk(`AMR_IDX_POSSEL, 32'h0);
        rdChk(`AMR_IDX_NEGSEL, 32'h0);
        rdChk(`AMR_IDX_AMPCTRL, {24'h0, `AMR_AMPCTRL_RESET});
        for (int i = 0; i < 6; i++) rdChk(`AMR_IDX_RESULT0 + 6'(i), 32'h0);
        $display("test reset values done");
        foreach (rows[i]) begin
            wr8(rows[i].neg ? `AMR_IDX_NEGSEL : `AMR_IDX_POSSEL, rows[i].wr);
            settle();
            `CHK(rows[i].neg ? 3'(negKind) : 3'(posKind), rows[i].kind)
            `CHK(rows[i].neg ? negPin : posPin, rows[i].pin)
            rdChk(rows[i].neg ? `AMR_IDX_NEGSEL : `AMR_IDX_POSSEL, {24'h0, rows[i].wr});
        end
        $display("test selector table done");
        wr8(`AMR_IDX_POSSEL, 8'h45);
        rdChk(`AMR_IDX_NEGSEL, 32'h70);
        wr8(`AMR_IDX_NEGSEL, 8'h02);
        rdChk(`AMR_IDX_POSSEL, 32'h05);
        for (int i = 0; i < 4; i++) begin
            wr8(`AMR_IDX_AMPCTRL, 8'(i << 3));
            settle();
            `CHK(ampBias, 2'(i))
        end
        for (int i = 0; i < 8; i++) begin
            wr8(`AMR_IDX_CONTROL, {7'h0, i[2]});
            wr8(`AMR_IDX_POSSEL, {1'b0, i[1], 6'h01});
            wr8(`AMR_IDX_AMPCTRL, {7'h0, i[0]});
            settle();
            `CHK(routeViaAmp, i[1])
            `CHK(ampPowerOn, i[0] & (i[1] | i[2]))
        end
        $display("test amplifier control done");
        @(posedge ref_clk);
        convResult <= 32'h44332211;
        convSample <= 16'hbbaa;
        convDone <= 1'b1;
        @(posedge ref_clk);
        convDone <= 1'b0;
        for (int i = 0; i < 4; i++) rdChk(`AMR_IDX_RESULT0 + 6'(i), 32'(8'h11 * (i + 1)));
        rdChk(`AMR_IDX_SAMPLE0, 32'haa);
        rdChk(`AMR_IDX_SAMPLE1, 32'hbb);
        wr8(`AMR_IDX_RESULT0, 8'h5a);
        `CHK(errv, 1'b0)
        rdChk(`AMR_IDX_RESULT0, 32'h11);
        $display("test results done");
        wr8(`AMR_IDX_CLKDIV, 8'h00);
        wr8(`AMR_IDX_SAMPLEN, 8'h02);
        wr8(`AMR_IDX_COMMAND, {5'h0, `AMR_START_ON_POS});
        for (int c = 0; c < 3; c++) begin
            wr8(`AMR_IDX_AMPCTRL, 8'(c << 1));
            runConv(`AMR_IDX_POSSEL, 8'h41, 3, ampLen[c]);
        end
        wr8(`AMR_IDX_COMMAND, {5'h0, `AMR_START_ON_NEG});
        wr8(`AMR_IDX_POSSEL, 8'h41);
        @(negedge ref_clk);
        `CHK(convStart, 1'b0)
        runConv(`AMR_IDX_NEGSEL, 8'h41, 3, ampLen[2]);
        $display("test conversion start done");
        // divider at 3: one converter tick every fourth cycle
        wr8(`AMR_IDX_CLKDIV, 8'h03);
        nTick = 0;
        repeat (40) begin
            @(negedge ref_clk);
            nTick += int'(adcTick === 1'b1);
        end
        `CHK(nTick, 10)
        $display("test converter tick done");
        apb(1'b0, 8'h60, 32'h0, rdv, errv);
        `CHK(errv, 1'b1)
        `CHK(rdv, 32'h0)
        apb(1'b1, 8'h31, 32'hff, rdv, errv);
        `CHK(errv, 1'b1)
        rdChk(`AMR_IDX_POSSEL, 32'h41);
        $display("test refused accesses done");
        rst_b <= 1'b0;
        @(negedge ref_clk);
        `CHK(routeViaAmp, 1'b0)
        `CHK(posKind, AMR_IN_GROUND)
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdChk(`AMR_IDX_NEGSEL, 32'h0);
        rdChk(`AMR_IDX_RESULT3, 32'h0);
        $display("test second reset done");
        stop_test();
    end
endmodule
